/* ppgc_pkg.sv */
// Purpose: constants and types of the pattern packet generator and checker
// Assumes: apb byte address = register index * 4, 16-bit data in low bits
// Notes:   interrupt status and mask sit at indices of their own
//
// Notes on behaviour
// [R1] writing send starts one fixed or incrementing packet when enabled, not random
// [R2] send bit drops by itself when the completion flag sets
// [R3] checker source field picks rgmii, rmii, mii tx or copper rx; resets 0x5
// [R4] generator destination field picks rgmii, rmii, mii rx or copper tx; resets 0x7
// [R5] continuous count mode: counter at max pulses and restarts from zero
// [R6] single count mode: any counter at max halts all counting
// [R7] checker input enable must be set for data and packet counts
// [R8] random select and enable set: random packets sent back to back forever
// [R9] random select set, enable clear: checker stays active
// [R10] random select clear, enable set: non-random packet generated
// [R11] random select and enable both clear: checker switched off
// [R12] generator enable bit turns the generator on and off
// [R13] length field sets payload bytes, without addresses and crc
// [R14] gap field sets idle bytes between consecutive packets
// [R15] fixed pattern enable repeats the four-bit pattern as payload
// [R16] completion flag sets once the requested crc packet is sent
// [R17] status word bit 0 freezes counters, bit 1 freezes then clears them
package ppgc_pkg;

   localparam logic [9:0]  IDX_CTRL     = 10'h119;
   localparam logic [9:0]  IDX_LEN      = 10'h11a;
   localparam logic [9:0]  IDX_GAP      = 10'h11b;
   localparam logic [9:0]  IDX_BYTES    = 10'h11c;
   localparam logic [9:0]  IDX_PKT_LO   = 10'h11d;
   localparam logic [9:0]  IDX_PKT_HI   = 10'h11e;
   localparam logic [9:0]  IDX_STAT     = 10'h11f;
   localparam logic [9:0]  IDX_IRQ_STS  = 10'h130;
   localparam logic [9:0]  IDX_IRQ_MSK  = 10'h131;

   localparam logic [15:0] CTRL_RST     = 16'h0574;
   localparam logic [15:0] LEN_RST      = 16'h05dc;
   localparam logic [15:0] GAP_RST      = 16'h007d;
   localparam logic [15:0] CTRL_WMASK   = 16'h177f;
   localparam logic [15:0] GAP_WMASK    = 16'h1fff;

   localparam int unsigned B_SEND       = 12;
   localparam int unsigned F_CHK_SEL    = 8;
   localparam int unsigned F_GEN_SEL    = 4;
   localparam int unsigned B_CNT_MODE   = 3;
   localparam int unsigned B_CHK_EN     = 2;
   localparam int unsigned B_RAND       = 1;
   localparam int unsigned B_GEN_EN     = 0;
   localparam int unsigned B_FIX_EN     = 12;
   localparam int unsigned F_FIX_PATT   = 8;
   localparam int unsigned F_GAP        = 0;
   localparam int unsigned B_CMD_FREEZE = 0;
   localparam int unsigned B_CMD_CLEAR  = 1;
   localparam int unsigned B_LOSS_KEEP  = 13;

   localparam logic [2:0]  PATH_RGMII   = 3'h0;
   localparam logic [2:0]  PATH_RMII    = 3'h2;
   localparam logic [2:0]  PATH_MII     = 3'h3;
   localparam logic [2:0]  PATH_COPPER  = 3'h5;

   localparam int unsigned IRQ_W        = 3;
   localparam int unsigned IRQ_DONE     = 0;
   localparam int unsigned IRQ_WRAP     = 1;
   localparam int unsigned IRQ_LOSS     = 2;

   localparam logic [15:0] HDR_LAST     = 16'h000b;
   localparam logic [15:0] CRC_LAST     = 16'h0003;
   // 12 header bytes plus the 4-byte delay line
   localparam logic [4:0]  POS_CHECK    = 5'h10;
   localparam logic [31:0] CRC_INIT     = 32'hffffffff;
   localparam logic [31:0] CRC_POLY     = 32'hedb88320;
   localparam logic [14:0] PRBS_SEED    = 15'h7fff;
   localparam logic [7:0]  DST_BYTE     = 8'hff;
   localparam logic [7:0]  SRC_BYTE     = 8'h02;
   localparam logic [15:0] BYTE_MAX     = 16'hffff;
   localparam logic [31:0] PKT_MAX      = 32'hffffffff;
   localparam logic [7:0]  ERR_MAX      = 8'hff;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } ppgc_strm_t;

   typedef enum logic [2:0] {
      GS_IDLE = 3'b000,
      GS_HDR  = 3'b001,
      GS_PAY  = 3'b010,
      GS_CRC  = 3'b011,
      GS_GAP  = 3'b100
   } ppgc_gst_t;

endpackage

/* ppgc_top.sv */
// Purpose: test traffic generator and pseudo-random checker, apb registers
// Assumes: traffic ports are same-clock logic, one byte per valid cycle
// Notes:   stream index 0 rgmii, 1 rmii, 2 mii, 3 copper
`timescale 1ns/1ps
module ppgc_top
   import ppgc_pkg::*;
#(
   parameter int unsigned LOCK_MATCHES = 8,
   parameter int unsigned LOSS_MISSES  = 4
)(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // traffic
   input  wire ppgc_strm_t [3:0] chk_in,
   output ppgc_strm_t      [3:0] gen_out,
   // events
   output logic                  wrap_pulse,
   output logic                  irq
);

   if (LOCK_MATCHES < 1 || LOCK_MATCHES > 255 ||
       LOSS_MISSES < 1 || LOSS_MISSES > 255)
   begin : g_bad_param
      $error("lock thresholds must be 1 to 255");
   end

   localparam logic [7:0] LOCK_LAST = 8'(LOCK_MATCHES - 1);
   localparam logic [7:0] LOSS_LAST = 8'(LOSS_MISSES - 1);

   function automatic logic [3:0] path_onehot(input logic [2:0] code);
      case (code)
         PATH_RGMII:  path_onehot = 4'h1;
         PATH_RMII:   path_onehot = 4'h2;
         PATH_MII:    path_onehot = 4'h4;
         PATH_COPPER: path_onehot = 4'h8;
         default:     path_onehot = 4'h0;
      endcase
   endfunction

   function automatic logic [7:0] prbs_byte(input logic [14:0] s);
      logic [14:0] t;
      logic        b;
      t = s;
      prbs_byte = 8'h00;
      for (int i = 7; i >= 0; i--)
      begin
         b = t[14] ^ t[13];
         prbs_byte[i] = b;
         t = {t[13:0], b};
      end
   endfunction

   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0]  d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r >> 1) ^ (CRC_POLY & {32{r[0] ^ d[i]}});
      crc_byte = r;
   endfunction

   function automatic logic [3:0] ones(input logic [7:0] v);
      ones = 4'h0;
      for (int i = 0; i < 8; i++)
         ones = ones + {3'h0, v[i]};
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction

   // registers
   logic [15:0]      ctrl_q, len_q, gap_q;
   logic [IRQ_W-1:0] ists_q, imsk_q;
   logic             done_q, lock_q, loss_q, halt_q, byte_ov_q, pkt_ov_q;
   logic [15:0]      bytes_q, snap_bytes_q;
   logic [31:0]      pkts_q, snap_pkts_q;
   logic [7:0]       errs_q, snap_errs_q;

   // apb decode
   wire  [9:0]  pidx     = paddr[11:2];
   wire         setup    = psel & ~penable;
   wire         wr       = psel & penable & pready & pwrite;
   wire         hit      = pidx == IDX_CTRL || pidx == IDX_LEN ||
                           pidx == IDX_GAP || pidx == IDX_BYTES ||
                           pidx == IDX_PKT_LO || pidx == IDX_PKT_HI ||
                           pidx == IDX_STAT || pidx == IDX_IRQ_STS ||
                           pidx == IDX_IRQ_MSK;
   wire         wr_ctrl  = wr & (pidx == IDX_CTRL);
   wire         wr_len   = wr & (pidx == IDX_LEN);
   wire         wr_gap   = wr & (pidx == IDX_GAP);
   wire         wr_stat  = wr & (pidx == IDX_STAT) & pstrb[0];
   wire         wr_ists  = wr & (pidx == IDX_IRQ_STS) & pstrb[0];
   wire         wr_imsk  = wr & (pidx == IDX_IRQ_MSK) & pstrb[0];
   wire         clr_cmd  = wr_stat & pwdata[B_CMD_CLEAR];
   wire         frz_cmd  = wr_stat & (pwdata[B_CMD_FREEZE] |
                                      pwdata[B_CMD_CLEAR]);

   // control fields
   wire         gen_en   = ctrl_q[B_GEN_EN];
   wire         rand_sel = ctrl_q[B_RAND];
   wire         send     = ctrl_q[B_SEND];
   wire         cont     = ctrl_q[B_CNT_MODE];
   wire  [3:0]  gen_oh   = path_onehot(ctrl_q[F_GEN_SEL +: 3]);     // R4
   wire  [3:0]  chk_oh   = path_onehot(ctrl_q[F_CHK_SEL +: 3]);     // R3
   wire  [7:0]  ipg      = gap_q[F_GAP +: 8];
   wire  [3:0]  patt     = gap_q[F_FIX_PATT +: 4];
   wire         fix_en   = gap_q[B_FIX_EN];

   // generator
   ppgc_gst_t   gst_q, gst_d;
   logic [15:0] gcnt_q, gcnt_d;
   logic [31:0] crc_q;
   logic [14:0] gps_q;
   logic        pkt_end;

   always_comb
   begin
      gst_d   = gst_q;
      gcnt_d  = gcnt_q + 16'h0001;
      pkt_end = 1'b0;
      if (!gen_en)                                                  // R12
      begin
         gst_d  = GS_IDLE;
         gcnt_d = '0;
      end
      else
         case (gst_q)
            GS_IDLE:
            begin
               gcnt_d = '0;
               if (rand_sel | send)                                 // R1 R10
                  gst_d = GS_HDR;
            end
            GS_HDR:
               if (gcnt_q == HDR_LAST)
               begin
                  gcnt_d = '0;
                  gst_d  = (len_q == '0) ? GS_CRC : GS_PAY;
               end
            GS_PAY:
               if (gcnt_q == len_q - 16'h0001)                      // R13
               begin
                  gcnt_d = '0;
                  gst_d  = GS_CRC;
               end
            GS_CRC:
               if (gcnt_q == CRC_LAST)
               begin
                  pkt_end = 1'b1;
                  gcnt_d  = '0;
                  if (ipg != '0)
                     gst_d = GS_GAP;
                  else
                     gst_d = rand_sel ? GS_HDR : GS_IDLE;           // R8
               end
            GS_GAP:
               if (gcnt_q == {8'h00, ipg} - 16'h0001)               // R14
               begin
                  gcnt_d = '0;
                  gst_d  = rand_sel ? GS_HDR : GS_IDLE;             // R8
               end
            default:
            begin
               gst_d  = GS_IDLE;
               gcnt_d = '0;
            end
         endcase
   end

   wire         enter_hdr = (gst_d == GS_HDR) & (gst_q != GS_HDR);
   wire         done_set  = pkt_end & ~rand_sel;                    // R16
   wire  [31:0] crc_inv   = ~crc_q;
   wire  [7:0]  hdr_b     = (gcnt_q < 16'h0006) ? DST_BYTE :
                            (gcnt_q == 16'h0006) ? SRC_BYTE : gcnt_q[7:0];
   wire  [7:0]  prbs_b    = prbs_byte(gps_q);
   wire  [7:0]  pay_b     = fix_en   ? {patt, patt} :               // R15
                            rand_sel ? prbs_b : gcnt_q[7:0];
   wire  [7:0]  cur_b     = (gst_q == GS_HDR) ? hdr_b :
                            (gst_q == GS_PAY) ? pay_b :
                            crc_inv[{gcnt_q[1:0], 3'b000} +: 8];
   wire         cur_v     = gen_en & ((gst_q == GS_HDR) |
                            (gst_q == GS_PAY) | (gst_q == GS_CRC));
   wire         cur_last  = (gst_q == GS_CRC) & (gcnt_q == CRC_LAST);
   wire         in_frame  = (gst_q == GS_HDR) | (gst_q == GS_PAY);

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         gst_q  <= GS_IDLE;
         gcnt_q <= '0;
      end
      else
      begin
         gst_q  <= gst_d;
         gcnt_q <= gcnt_d;
      end

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         crc_q <= CRC_INIT;
         gps_q <= PRBS_SEED;
      end
      else
      begin
         if (enter_hdr)
            crc_q <= CRC_INIT;
         else if (cur_v & in_frame)
            crc_q <= crc_byte(crc_q, cur_b);
         if (cur_v & (gst_q == GS_PAY) & rand_sel)
            gps_q <= {gps_q[6:0], prbs_b};
      end

   for (genvar i = 0; i < 4; i++)
   begin : g_out
      always_ff @(posedge clk_sys or negedge arst_n)
         if (!arst_n)
            gen_out[i] <= '0;
         else
            gen_out[i] <= '{valid: cur_v & gen_oh[i],               // R4
                            last:  cur_last, data: cur_b};
   end

   // checker
   ppgc_strm_t  chk_s;
   logic [4:0]  pos_q;
   logic [7:0]  pipe_q [4];
   logic [14:0] cst_q;
   logic [7:0]  run_q, miss_q;

   always_comb
   begin
      chk_s = '0;
      for (int i = 0; i < 4; i++)
         if (chk_oh[i])
            chk_s = chk_in[i];                                      // R3
   end

   wire         chk_on   = ctrl_q[B_CHK_EN] & (rand_sel | gen_en);  // R7 R9 R11
   wire         rx       = chk_on & chk_s.valid;
   wire         chk_now  = rx & (pos_q >= POS_CHECK);
   wire  [7:0]  pred     = prbs_byte(cst_q);
   wire         match    = pipe_q[3] == pred;
   wire         miss_end = chk_now & lock_q & ~match & (miss_q == LOSS_LAST);
   wire         lock_set = chk_now & ~lock_q & match & (run_q == LOCK_LAST);

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         pos_q  <= '0;
         pipe_q <= '{default: '0};
         cst_q  <= PRBS_SEED;
      end
      else if (rx)
      begin
         pos_q  <= chk_s.last ? '0 :
                   (pos_q == POS_CHECK) ? pos_q : pos_q + 5'h01;
         pipe_q <= '{chk_s.data, pipe_q[0], pipe_q[1], pipe_q[2]};
         if (chk_now)
            cst_q <= {cst_q[6:0], pipe_q[3]};
      end

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         lock_q <= 1'b0;
         run_q  <= '0;
         miss_q <= '0;
      end
      else if (!chk_on)
      begin
         lock_q <= 1'b0;
         run_q  <= '0;
         miss_q <= '0;
      end
      else if (chk_now)
      begin
         lock_q <= (lock_q & ~miss_end) | lock_set;
         run_q  <= (match & ~lock_set) ? run_q + 8'h01 : '0;
         miss_q <= (match | miss_end) ? '0 : miss_q + 8'h01;
      end

   // counters
   wire         byte_inc = rx & ~halt_q;                            // R7
   wire         pkt_inc  = rx & chk_s.last & ~halt_q;               // R7
   wire  [3:0]  err_bits = (chk_now & lock_q & ~halt_q) ?
                           ones(pipe_q[3] ^ pred) : 4'h0;
   wire  [8:0]  err_sum  = {1'b0, errs_q} + {5'h00, err_bits};
   wire         byte_top = byte_inc & (bytes_q == BYTE_MAX);
   wire         pkt_top  = pkt_inc & (pkts_q == PKT_MAX);
   wire         err_top  = err_sum[8];
   wire         wrap_evt = cont & (byte_top | pkt_top | err_top);   // R5
   wire  [15:0] bytes_d  = byte_top ? '0 : bytes_q + {15'h0, byte_inc};
   wire  [31:0] pkts_d   = pkt_top ? '0 : pkts_q + {31'h0, pkt_inc};
   wire  [7:0]  errs_d   = (err_top & ~cont) ? ERR_MAX : err_sum[7:0];
   wire         at_max   = bytes_d == BYTE_MAX || pkts_d == PKT_MAX ||
                           errs_d == ERR_MAX;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         bytes_q <= '0;
         pkts_q  <= '0;
         errs_q  <= '0;
      end
      else if (clr_cmd)                                             // R17
      begin
         bytes_q <= '0;
         pkts_q  <= '0;
         errs_q  <= '0;
      end
      else
      begin
         bytes_q <= bytes_d;                                        // R5 R6
         pkts_q  <= pkts_d;
         errs_q  <= errs_d;
      end

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         halt_q    <= 1'b0;
         byte_ov_q <= 1'b0;
         pkt_ov_q  <= 1'b0;
      end
      else if (clr_cmd)                                             // R17
      begin
         halt_q    <= 1'b0;
         byte_ov_q <= 1'b0;
         pkt_ov_q  <= 1'b0;
      end
      else
      begin
         halt_q    <= halt_q | (~cont & at_max);                    // R6
         byte_ov_q <= byte_ov_q | (bytes_d == BYTE_MAX) | byte_top;
         pkt_ov_q  <= pkt_ov_q | (pkts_d == PKT_MAX) | pkt_top;
      end

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         snap_bytes_q <= '0;
         snap_pkts_q  <= '0;
         snap_errs_q  <= '0;
      end
      else if (frz_cmd)                                             // R17
      begin
         snap_bytes_q <= bytes_q;
         snap_pkts_q  <= pkts_q;
         snap_errs_q  <= errs_q;
      end

   // control and status registers
   wire  [15:0] ctrl_wr  = merge16(ctrl_q, pwdata, pstrb) & CTRL_WMASK;
   wire  [15:0] ctrl_d   = wr_ctrl ? ctrl_wr :
                           (ctrl_q & ~({15'h0, done_set} << B_SEND)); // R2
   wire         loss_clr = wr_stat & ~pwdata[B_LOSS_KEEP];
   wire  [IRQ_W-1:0] ev  = {miss_end, wrap_evt, done_set};

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         ctrl_q <= CTRL_RST;                                        // R3 R4
         len_q  <= LEN_RST;                                         // R13
         gap_q  <= GAP_RST;                                         // R14
         imsk_q <= '0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         len_q  <= wr_len ? merge16(len_q, pwdata, pstrb) : len_q;
         gap_q  <= wr_gap ? merge16(gap_q, pwdata, pstrb) & GAP_WMASK
                          : gap_q;
         imsk_q <= wr_imsk ? pwdata[IRQ_W-1:0] : imsk_q;
      end

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         done_q     <= 1'b0;
         loss_q     <= 1'b0;
         ists_q     <= '0;
         irq        <= 1'b0;
         wrap_pulse <= 1'b0;
      end
      else
      begin
         done_q     <= done_set | (done_q & ~(enter_hdr & ~rand_sel)); // R16
         loss_q     <= miss_end | (loss_q & ~loss_clr);
         ists_q     <= ev | (ists_q & ~(wr_ists ? pwdata[IRQ_W-1:0] : '0));
         irq        <= |(ists_q & imsk_q);
         wrap_pulse <= wrap_evt;                                    // R5
      end

   // apb answer
   wire  [15:0] stat_rd  = {2'b00, loss_q, done_q, gst_q != GS_IDLE,
                            pkt_ov_q, byte_ov_q, lock_q, snap_errs_q};
   wire  [15:0] rd_word  =
      (pidx == IDX_CTRL)    ? ctrl_q :
      (pidx == IDX_LEN)     ? len_q :
      (pidx == IDX_GAP)     ? gap_q :
      (pidx == IDX_BYTES)   ? snap_bytes_q :
      (pidx == IDX_PKT_LO)  ? snap_pkts_q[15:0] :
      (pidx == IDX_PKT_HI)  ? snap_pkts_q[31:16] :
      (pidx == IDX_STAT)    ? stat_rd :
      (pidx == IDX_IRQ_STS) ? {13'h0, ists_q} :
      (pidx == IDX_IRQ_MSK) ? {13'h0, imsk_q} : 16'h0000;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= setup ? {16'h0000, rd_word} : prdata;
      end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence last_crc_s;
      gst_q == GS_CRC && gcnt_q == CRC_LAST && gen_en;
   endsequence

   sequence restart_s;
      gst_q == GS_GAP && gcnt_q == {8'h00, ipg} - 16'h0001 && gen_en;
   endsequence

   send_clear_a: assert property (                                  // R2
      last_crc_s ##0 (!rand_sel && !wr_ctrl) |=> !send && done_q)
      else $error("send bit not cleared at completion");
   start_once_a: assert property (                                  // R1
      gst_q == GS_IDLE && gen_en && !rand_sel && send |=>
      gst_q == GS_HDR ##[1:12] gen_out[0].valid || gen_out[1].valid ||
      gen_out[2].valid || gen_out[3].valid || gen_oh == 4'h0)
      else $error("single packet did not start");
   dest_route_a: assert property (                                  // R4
      gen_out[3].valid |-> $past(ctrl_q[F_GEN_SEL +: 3]) == PATH_COPPER)
      else $error("copper output used for another destination");
   rand_loop_a: assert property (                                   // R8
      restart_s ##0 rand_sel |=> gst_q == GS_HDR)
      else $error("random traffic stopped between packets");
   len_end_a: assert property (                                     // R13
      gst_q == GS_PAY && gen_en && gcnt_q == len_q - 16'h0001
      |=> gst_q == GS_CRC ##1 gst_q == GS_CRC)
      else $error("payload length not honoured");
   gap_hold_a: assert property (                                    // R14
      $rose(gst_q == GS_GAP) && ipg == 8'h03 && gen_en && !wr_gap
      |-> (gst_q == GS_GAP) [*3] ##1 gst_q != GS_GAP)
      else $error("gap length not honoured");
   fix_patt_a: assert property (                                    // R15
      gst_q == GS_PAY && gen_en && fix_en |=>
      gen_out[0].data == {$past(patt), $past(patt)})
      else $error("fixed pattern missing from payload");
   halt_hold_a: assert property (                                   // R6
      halt_q && !clr_cmd |=> $stable(bytes_q) && $stable(pkts_q))
      else $error("counting continued after halt");
   wrap_zero_a: assert property (                                   // R5
      cont && byte_top && !clr_cmd |=> bytes_q == '0 && wrap_pulse)
      else $error("byte counter did not wrap with pulse");
   chk_gate_a: assert property (                                    // R7 R11
      (!ctrl_q[B_CHK_EN] || (!rand_sel && !gen_en)) && !clr_cmd
      |=> $stable(bytes_q))
      else $error("checker counted while disabled");
   clear_cnt_a: assert property (                                   // R17
      clr_cmd |=> bytes_q == '0 && pkts_q == '0 && !pkt_ov_q &&
      snap_bytes_q == $past(bytes_q))
      else $error("clear command did not freeze and clear");

endmodule

/* ppgc_far_end.sv */
// Purpose: far end model, copper line looped back into the checker
// Assumes: one byte per cycle on the same clock
// Notes:   idle paths show a toggling byte, never stale data
`timescale 1ns/1ps
module ppgc_far_end
   import ppgc_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // traffic
   input  wire ppgc_strm_t [3:0] gen,
   output ppgc_strm_t      [3:0] chk
);
   logic [7:0] tog_q;
   ppgc_strm_t line_q;
   ppgc_strm_t idle;
   assign idle = '{valid: 1'b0, last: 1'b0, data: tog_q};
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         tog_q  <= 8'h00;
         line_q <= '0;
      end
      else
      begin
         tog_q  <= ~tog_q;
         line_q <= gen[3];
      end
   always_comb
   begin
      chk    = {idle, idle, idle, idle};
      chk[3] = line_q.valid ? line_q : idle;
   end
endmodule

/* ppgc_top_bench.sv */
// Purpose: bench for the pattern generator and checker
// Assumes: copper tx looped to copper rx by the far end model
// Notes:   crc bytes checked against a bench crc model
`timescale 1ns/1ps
module ppgc_top_bench;
   import ppgc_pkg::*;
   logic             clk_sys = 0;
   logic             arst_n = 0;
   logic             psel = 0;
   logic             penable = 0;
   logic             pwrite = 0;
   logic [11:0]      paddr = '0;
   logic [31:0]      pwdata = '0;
   logic [31:0]      prdata, r;
   logic             pready, pslverr, wrap_pulse, irq, e;
   ppgc_strm_t [3:0] chk_in, gen_out;
   int               error_cnt = 0, n_tests = 0, cyc = 0, len, exp_b = 0;
   int               npk = 0;
   logic [15:0]      seed = 16'hbb88;
   logic [7:0]       got[$];
   always #2 clk_sys = ~clk_sys;
   ppgc_top dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chk_in(chk_in), .gen_out(gen_out), .wrap_pulse(wrap_pulse), .irq(irq));
   ppgc_far_end far_u (.clk_sys(clk_sys), .arst_n(arst_n), .gen(gen_out),
      .chk(chk_in));
   always @(posedge clk_sys)
      if (gen_out[3].valid === 1'b1)
      begin
         got.push_back(gen_out[3].data);
         npk += gen_out[3].last;
      end
   function automatic logic [15:0] xs(input logic [15:0] s);
      s ^= s << 7;
      s ^= s >> 9;
      return s ^ (s << 8);
   endfunction
   function automatic logic [31:0] crc_of(input int n);
      logic [31:0] c;
      c = CRC_INIT;
      for (int k = 0; k < n; k++)
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ (c[0] ^ got[k][b] ? CRC_POLY : 32'h0);
      return ~c;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one apb transfer, waits for pready, then one idle cycle
   task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0, d};
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         finish_test;
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1;
      @(posedge clk_sys);
      apb(0, IDX_CTRL, 0);
      check("ctrl rst", r, CTRL_RST);
      apb(0, IDX_LEN, 0);
      check("len rst", r, LEN_RST);
      apb(0, IDX_GAP, 0);
      check("gap rst", r, GAP_RST);
      apb(1, 10'h3ff, 16'hffff);
      check("unmapped err", e, 1);
      for (int m = 0; m < 2; m++)
      begin
         seed = xs(seed);
         len = 4 + seed[3:0];
         exp_b += 16 + len;
         got.delete();
         apb(1, IDX_LEN, len[15:0]);
         apb(1, IDX_GAP, m ? 16'h0 : {4'h1, seed[7:4], 8'h00});
         apb(1, IDX_CTRL, 16'h1555);
         r = 0;
         while (r[12] !== 1'b1) apb(0, IDX_STAT, 0);
         apb(0, IDX_CTRL, 0);
         check("send clr", r, 16'h0555);
         check("frame len", got.size(), 16 + len);
         for (int i = 0; i < 12 + len; i++)
            check("byte", got[i], i < 6 ? 8'hff : i == 6 ? 8'h02 : i < 12 ? i
               : m ? i - 12 : {seed[7:4], seed[7:4]});
         check("crc", {got[15+len], got[14+len], got[13+len], got[12+len]},
            crc_of(12 + len));
      end
      check("irq masked", irq, 0);
      apb(1, IDX_IRQ_MSK, 16'h0007);
      @(posedge clk_sys);
      check("irq", irq, 1);
      apb(1, IDX_IRQ_STS, 16'h0007);
      @(posedge clk_sys);
      check("irq clr", irq, 0);
      apb(1, IDX_IRQ_MSK, 16'h0000);
      apb(1, IDX_STAT, 16'h0001);
      apb(0, IDX_PKT_LO, 0);
      check("pkts", r, 2);
      apb(0, IDX_BYTES, 0);
      check("bytes", r, exp_b);
      apb(1, IDX_STAT, 16'h0002);
      apb(1, IDX_STAT, 16'h0001);
      apb(0, IDX_BYTES, 0);
      check("bytes clr", r, 0);
      // random traffic with a gap, then generator off, then checker off
      got.delete();
      npk = 0;
      apb(1, IDX_LEN, 16'h0014);
      apb(1, IDX_GAP, 16'h0003);
      apb(1, IDX_CTRL, 16'h0557);
      repeat (150) @(posedge clk_sys);
      apb(1, IDX_CTRL, 16'h0556);
      repeat (4) @(posedge clk_sys);
      apb(1, IDX_STAT, 16'h0001);
      apb(0, IDX_STAT, 0);
      check("lock", r[11:0], 12'h100);
      apb(0, IDX_BYTES, 0);
      check("rand bytes", r, got.size());
      apb(0, IDX_PKT_LO, 0);
      check("rand pkts", r, npk);
      apb(1, IDX_CTRL, 16'h0554);
      apb(0, IDX_STAT, 0);
      check("lock off", r[8], 0);
      finish_test;
   end
endmodule
